// [hdl/pcr_regs.svh]
// Constants for the privileged call/return control block.
// Included by the package user files; definitions only.
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH
`define PCR_GPR_COUNT      4'h8
`define PCR_IDX_ACC        3'h0
`define PCR_IDX_CNT        3'h1
`define PCR_IDX_DAT        3'h2
`define PCR_IDX_BAS        3'h3
`define PCR_IDX_SP         3'h4
`define PCR_IDX_FBP        3'h5
`define PCR_IDX_SRC        3'h6
`define PCR_IDX_DST        3'h7
`define PCR_WORD_BYTES     64'h0000000000000008
`define PCR_LEGACY_BYTES   64'h0000000000000004
`define PCR_RING_KERNEL    2'h0
`define PCR_RING_USER      2'h3
`define PCR_FLAGS_RESET    32'h00000002
`define PCR_SP_RESET       64'h0000000000001000
`define PCR_PARM_W         5
`endif

// [hdl/pcr_pkg.sv]
// Types shared by the call/return control block.
// Assumes pcr_regs.svh sits on the include path.
package pcr_pkg;
  typedef enum logic [3:0] {
    PCR_OP_NONE      = 4'h0,
    PCR_OP_PUSHALL   = 4'h1,
    PCR_OP_POPALL    = 4'h2,
    PCR_OP_PUSH_FLAGS_WORD_W   = 4'h3,
    PCR_OP_PUSH_FLAGS_WORD_D   = 4'h4,
    PCR_OP_POP_FLAGS_WORD_W    = 4'h5,
    PCR_OP_POP_FLAGS_WORD_D    = 4'h6,
    PCR_OP_FARCALL   = 4'h7,
    PCR_OP_FARRET    = 4'h8,
    PCR_OP_NEARBR    = 4'h9,
    PCR_OP_JCZ       = 4'ha,
    PCR_OP_SYSENTRY  = 4'hb,
    PCR_OP_SYSEXIT   = 4'hc
  } pcr_op_t;
  typedef enum logic [3:0] {
    PCR_IDLE   = 4'h0,
    PCR_PUSH_ALL_GENERAL  = 4'h1,
    PCR_POP_ALL_GENERAL   = 4'h2,
    PCR_CSAVE  = 4'h3,
    PCR_CPSS   = 4'h4,
    PCR_CPSP   = 4'h5,
    PCR_CPARM  = 4'h6,
    PCR_CPCS   = 4'h7,
    PCR_CPIP   = 4'h8,
    PCR_RIP    = 4'h9,
    PCR_RCS    = 4'ha,
    PCR_RSP    = 4'hb,
    PCR_RSS    = 4'hc,
    PCR_FPOP   = 4'hd
  } pcr_state_t;
endpackage

// [hdl/pcr_ring_stack.sv]
// Per-ring stack selector/pointer store for rings 0..2.
// Assumes writes come from the sequencer; read data is registered.
`timescale 1ns/10ps
module pcr_ring_stack (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_ring,
  input  wire logic [15:0] wr_sel,
  input  wire logic [63:0] wr_ptr,
  input  wire logic [1:0]  rd_ring,
  output logic      [15:0] rd_sel,
  output logic      [63:0] rd_ptr
);
  logic [15:0] sel_mem [0:3];
  logic [63:0] ptr_mem [0:3];
  logic [15:0] next_rd_sel;
  logic [63:0] next_rd_ptr;

  // Combinational read; registered below
  always_comb begin
    next_rd_sel = sel_mem[rd_ring];
    next_rd_ptr = ptr_mem[rd_ring];
  end

  // Entries reset to zero so an unprogrammed ring reads defined
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        sel_mem[i] <= 16'h0000;
        ptr_mem[i] <= 64'h0000000000000000;
      end
      rd_sel <= 16'h0000;
      rd_ptr <= 64'h0000000000000000;
    end else begin
      if (wr_en) begin
        sel_mem[wr_ring] <= wr_sel;
        ptr_mem[wr_ring] <= wr_ptr;
      end
      rd_sel <= next_rd_sel;
      rd_ptr <= next_rd_ptr;
    end
  end
endmodule

// [hdl/pcr_call_ctrl.sv]
// Call/return sequencer: register save/restore, gated inward calls, returns.
// Assumes one op per start pulse, a stack memory that answers every
// access in the same cycle (push writes, pop returns mem_rdata combinationally).
`timescale 1ns/10ps
`include "pcr_regs.svh"
module pcr_call_ctrl (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            start,
  input  pcr_pkg::pcr_op_t     op,
  input  wire logic            wide_mode,
  input  wire logic            opsize_prefix,
  input  wire logic            addr_prefix,
  input  wire logic            is_direct,
  input  wire logic            via_gate,
  input  wire logic [1:0]      gate_dpl,
  input  wire logic [1:0]      target_rpl,
  input  wire logic [15:0]     gate_cs,
  input  wire logic [63:0]     gate_offset,
  input  wire logic [4:0]      gate_parm_count,
  input  wire logic [63:0]     instr_offset,
  input  wire logic [31:0]     rel_disp,
  input  wire logic [15:0]     ret_bytes,
  input  wire logic            ring_wr,
  input  wire logic [1:0]      ring_wr_sel,
  input  wire logic [15:0]     ring_stack_sel,
  input  wire logic [63:0]     ring_stack_ptr,
  input  wire logic [63:0]     mem_rdata,
  output logic                 mem_we,
  output logic                 mem_re,
  output logic      [63:0]     mem_addr,
  output logic      [63:0]     mem_wdata,
  output logic                 busy,
  output logic                 done,
  output logic                 protection_fault,
  output logic      [1:0]      cur_ring,
  output logic      [15:0]     code_sel,
  output logic      [63:0]     wide_instruction_pointer,
  output logic      [15:0]     stack_sel,
  output logic      [63:0]     stack_pointer,
  output logic      [31:0]     flags_register,
  output logic      [63:0]     wide_count_register,
  output logic      [63:0]     accumulator_reg,
  output logic      [63:0]     data_reg,
  output logic      [63:0]     base_reg,
  output logic      [63:0]     frame_base_pointer,
  output logic      [63:0]     source_index,
  output logic      [63:0]     dest_index
);
  import pcr_pkg::*;

  pcr_state_t  state, next_state;
  logic [63:0] gpr [0:7];
  logic [63:0] next_gpr [0:7];
  logic [2:0]  idx, next_idx;
  logic [4:0]  cnt, next_cnt;
  logic [63:0] old_sp, next_old_sp, old_ip, next_old_ip;
  logic [15:0] old_ss, next_old_ss, old_cs, next_old_cs;
  logic [1:0]  old_ring, next_old_ring;
  logic [15:0] next_code_sel, next_stack_sel;
  logic [63:0] next_ip;
  logic [31:0] next_flags;
  logic [1:0]  next_ring;
  logic        next_done, next_fault;
  logic [63:0] wsz;
  logic [15:0] rs_sel;
  logic [63:0] rs_ptr;
  logic        rs_wr;
  logic [1:0]  rs_ring;

  // Word size: wide mode forces 8 bytes, prefixes ignored
  assign wsz = wide_mode ? `PCR_WORD_BYTES : `PCR_LEGACY_BYTES;

  // Inward transfer legal only through a gate with enough rights
  function automatic logic inward_ok(input logic gate, input logic [1:0] dpl,
                                     input logic [1:0] ring, input logic [1:0] tgt);
    inward_ok = gate ? (dpl <= ring) : (tgt >= ring);
  endfunction

  // Return may only move outward or stay level
  function automatic logic outward_ok(input logic [1:0] ring, input logic [1:0] tgt);
    outward_ok = (tgt >= ring);
  endfunction

  // Live ring 3 stack in stack regs; inner rings from store
  pcr_ring_stack u_ring_stack (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (rs_wr),
    .wr_ring (rs_ring),
    .wr_sel  (ring_stack_sel),
    .wr_ptr  (ring_stack_ptr),
    .rd_ring (gate_dpl),
    .rd_sel  (rs_sel),
    .rd_ptr  (rs_ptr)
  );
  assign rs_wr   = ring_wr && (ring_wr_sel != `PCR_RING_USER);
  assign rs_ring = ring_wr_sel;

  assign busy                     = (state != PCR_IDLE);
  assign accumulator_reg          = gpr[`PCR_IDX_ACC];
  assign wide_count_register      = gpr[`PCR_IDX_CNT];
  assign data_reg                 = gpr[`PCR_IDX_DAT];
  assign base_reg                 = gpr[`PCR_IDX_BAS];
  assign stack_pointer            = gpr[`PCR_IDX_SP];
  assign frame_base_pointer       = gpr[`PCR_IDX_FBP];
  assign source_index             = gpr[`PCR_IDX_SRC];
  assign dest_index               = gpr[`PCR_IDX_DST];

  // Sequencer next state; stack memory strobes are combinational
  always_comb begin
    next_state = state;
    for (int i = 0; i < 8; i++) next_gpr[i] = gpr[i];
    next_idx = idx;  next_cnt = cnt;
    next_old_sp = old_sp;  next_old_ip = old_ip;
    next_old_ss = old_ss;  next_old_cs = old_cs;  next_old_ring = old_ring;
    next_code_sel = code_sel;  next_stack_sel = stack_sel;
    next_ip = wide_instruction_pointer;  next_flags = flags_register;
    next_ring = cur_ring;  next_done = 1'b0;  next_fault = 1'b0;
    mem_we = 1'b0;  mem_re = 1'b0;
    mem_addr = gpr[`PCR_IDX_SP];  mem_wdata = 64'h0000000000000000;
    unique case (state)
      PCR_IDLE: begin
        if (start) begin
          unique case (op)
            PCR_OP_PUSHALL: begin
              next_old_sp = gpr[`PCR_IDX_SP];  // Pre-instruction value kept
              next_idx = 3'h0;
              next_state = PCR_PUSH_ALL_GENERAL;
            end
            PCR_OP_POPALL: begin
              next_idx = 3'h7;
              next_state = PCR_POP_ALL_GENERAL;
            end
            PCR_OP_PUSH_FLAGS_WORD_W, PCR_OP_PUSH_FLAGS_WORD_D: begin
              mem_we = 1'b1;
              mem_addr = gpr[`PCR_IDX_SP] - wsz;
              mem_wdata = (op == PCR_OP_PUSH_FLAGS_WORD_W) ? {48'h0, flags_register[15:0]}
                                                 : {32'h0, flags_register};
              next_gpr[`PCR_IDX_SP] = gpr[`PCR_IDX_SP] - wsz;
              next_done = 1'b1;
            end
            PCR_OP_POP_FLAGS_WORD_W, PCR_OP_POP_FLAGS_WORD_D: begin
              mem_re = 1'b1;
              next_flags = (op == PCR_OP_POP_FLAGS_WORD_W) ? {flags_register[31:16], mem_rdata[15:0]}
                                                 : mem_rdata[31:0];
              next_gpr[`PCR_IDX_SP] = gpr[`PCR_IDX_SP] + wsz;
              next_done = 1'b1;
            end
            PCR_OP_FARCALL: begin
              // Direct far refused in wide mode; failed check changes nothing
              if ((wide_mode && is_direct) ||
                  !inward_ok(via_gate, gate_dpl, cur_ring, target_rpl)) begin
                next_fault = 1'b1;
                next_done = 1'b1;
              end else begin
                // Hold caller context; no GPR or flag saving
                next_old_ss = stack_sel;  next_old_sp = gpr[`PCR_IDX_SP];
                next_old_cs = code_sel;   next_old_ip = wide_instruction_pointer;
                next_old_ring = cur_ring;
                next_cnt = via_gate ? gate_parm_count : 5'h00;
                next_state = PCR_CSAVE;
              end
            end
            PCR_OP_FARRET: begin
              if (!outward_ok(cur_ring, target_rpl)) begin
                next_fault = 1'b1;
                next_done = 1'b1;
              end else begin
                next_state = PCR_RIP;
              end
            end
            PCR_OP_NEARBR: begin
              // Displacement sign-extended from 32 bits
              next_ip = wide_instruction_pointer + {{32{rel_disp[31]}}, rel_disp};
              if (!wide_mode) next_ip[63:32] = 32'h0;
              next_done = 1'b1;
            end
            PCR_OP_JCZ: begin
              // Address prefix narrows count to 32 bits
              if ((wide_mode && !addr_prefix) ? (gpr[`PCR_IDX_CNT] == 64'h0)
                                              : (gpr[`PCR_IDX_CNT][31:0] == 32'h0))
                next_ip = wide_instruction_pointer + {{32{rel_disp[31]}}, rel_disp};
              next_done = 1'b1;
            end
            PCR_OP_SYSENTRY, PCR_OP_SYSEXIT: begin
              next_fault = !wide_mode;
              if (wide_mode) begin
                next_ring = (op == PCR_OP_SYSENTRY) ? `PCR_RING_KERNEL : `PCR_RING_USER;
                next_ip = gate_offset;
              end
              next_done = 1'b1;
            end
            default: next_done = 1'b0;
          endcase
        end
      end
      PCR_PUSH_ALL_GENERAL: begin
        mem_we = 1'b1;
        mem_addr = gpr[`PCR_IDX_SP] - wsz;
        mem_wdata = (idx == `PCR_IDX_SP) ? old_sp : gpr[idx];
        next_gpr[`PCR_IDX_SP] = gpr[`PCR_IDX_SP] - wsz;
        next_idx = idx + 3'h1;
        if (idx == 3'h7) begin
          next_state = PCR_IDLE;
          next_done = 1'b1;
        end
      end
      PCR_POP_ALL_GENERAL: begin
        mem_re = 1'b1;
        if (idx != `PCR_IDX_SP) next_gpr[idx] = mem_rdata;  // Saved pointer dropped
        next_gpr[`PCR_IDX_SP] = gpr[`PCR_IDX_SP] + wsz;
        next_idx = idx - 3'h1;
        if (idx == 3'h0) begin
          next_state = PCR_IDLE;
          next_done = 1'b1;
        end
      end
      PCR_CSAVE: begin
        // Store read has landed; switch when ring changes
        if (via_gate && gate_dpl < cur_ring) begin
          next_stack_sel = rs_sel;
          next_gpr[`PCR_IDX_SP] = rs_ptr;
          next_ring = gate_dpl;
          next_state = PCR_CPSS;
        end else begin
          next_state = PCR_CPCS;
        end
      end
      PCR_CPSS, PCR_CPSP: begin
        mem_we = 1'b1;
        mem_addr = gpr[`PCR_IDX_SP] - wsz;
        mem_wdata = (state == PCR_CPSS) ? {48'h0, old_ss} : old_sp;
        next_gpr[`PCR_IDX_SP] = gpr[`PCR_IDX_SP] - wsz;
        next_idx = 3'h0;
        next_state = (state == PCR_CPSS) ? PCR_CPSP
                   : ((cnt != 5'h00) ? PCR_CPARM : PCR_CPCS);
      end
      PCR_CPARM: begin
        // Alternate: read from old stack, then write to new
        if (idx == 3'h0) begin
          mem_re = 1'b1;
          mem_addr = old_sp + wsz * {59'h0, cnt - 5'h01};
          next_old_ip = mem_rdata;  // Staging reuses held IP slot; refilled from live IP after each write
          next_idx = 3'h1;
        end else begin
          mem_we = 1'b1;
          mem_addr = gpr[`PCR_IDX_SP] - wsz;
          mem_wdata = old_ip;
          next_gpr[`PCR_IDX_SP] = gpr[`PCR_IDX_SP] - wsz;
          next_old_ip = wide_instruction_pointer;
          next_cnt = cnt - 5'h01;
          next_idx = 3'h0;
          if (cnt == 5'h01) next_state = PCR_CPCS;
        end
      end
      PCR_CPCS, PCR_CPIP: begin
        mem_we = 1'b1;
        mem_addr = gpr[`PCR_IDX_SP] - wsz;
        mem_wdata = (state == PCR_CPCS) ? {48'h0, old_cs} : old_ip;
        next_gpr[`PCR_IDX_SP] = gpr[`PCR_IDX_SP] - wsz;
        next_state = (state == PCR_CPCS) ? PCR_CPIP : PCR_IDLE;
        if (state == PCR_CPIP) begin
          // Gate supplies selector and offset; upper 32 offset bits cleared outside wide mode
          next_code_sel = via_gate ? gate_cs : old_cs;
          next_ip = via_gate ? gate_offset : instr_offset;
          if (!wide_mode) next_ip[63:32] = 32'h0;
          next_done = 1'b1;
        end
      end
      PCR_RIP, PCR_RCS: begin
        mem_re = 1'b1;
        if (state == PCR_RIP) next_ip = mem_rdata;
        else next_code_sel = mem_rdata[15:0];
        next_gpr[`PCR_IDX_SP] = gpr[`PCR_IDX_SP] + wsz;
        if (state == PCR_RCS) begin
          // Release on privileged stack first
          next_gpr[`PCR_IDX_SP] = gpr[`PCR_IDX_SP] + wsz + {48'h0, ret_bytes};
          next_ring = target_rpl;
          if (target_rpl == cur_ring) begin
            next_state = PCR_IDLE;
            next_done = 1'b1;
          end else begin
            next_state = PCR_RSP;
          end
        end else begin
          next_state = PCR_RCS;
        end
      end
      PCR_RSP: begin
        mem_re = 1'b1;
        next_old_sp = mem_rdata;
        next_gpr[`PCR_IDX_SP] = gpr[`PCR_IDX_SP] + wsz;
        next_state = PCR_RSS;
      end
      PCR_RSS: begin
        // Back on caller stack, then release there too
        mem_re = 1'b1;
        next_stack_sel = mem_rdata[15:0];
        next_gpr[`PCR_IDX_SP] = old_sp + {48'h0, ret_bytes};
        next_state = PCR_IDLE;
        next_done = 1'b1;
      end
      default: next_state = PCR_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PCR_IDLE;
      for (int i = 0; i < 8; i++) gpr[i] <= 64'h0000000000000000;
      gpr[`PCR_IDX_SP] <= `PCR_SP_RESET;  // Room below for pushes
      idx <= 3'h0;  cnt <= 5'h00;
      old_sp <= 64'h0;  old_ip <= 64'h0;  old_ss <= 16'h0;  old_cs <= 16'h0;
      old_ring <= 2'h0;
      code_sel <= 16'h0000;  stack_sel <= 16'h0000;
      wide_instruction_pointer <= 64'h0;
      flags_register <= `PCR_FLAGS_RESET;
      cur_ring <= `PCR_RING_USER;
      done <= 1'b0;  protection_fault <= 1'b0;
    end else begin
      state <= next_state;
      for (int i = 0; i < 8; i++) gpr[i] <= next_gpr[i];
      idx <= next_idx;  cnt <= next_cnt;
      old_sp <= next_old_sp;  old_ip <= next_old_ip;
      old_ss <= next_old_ss;  old_cs <= next_old_cs;  old_ring <= next_old_ring;
      code_sel <= next_code_sel;  stack_sel <= next_stack_sel;
      wide_instruction_pointer <= next_ip;
      flags_register <= next_flags;
      cur_ring <= next_ring;
      done <= next_done;  protection_fault <= next_fault;
    end
  end
endmodule

// [sim/pcr_call_ctrl_checker.sv]
// Concurrent checks on the call/return sequencer's ports.
// Assumes the bind below and a single clock domain with async low reset.
`timescale 1ns/10ps
module pcr_call_ctrl_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        start,
  input pcr_pkg::pcr_op_t op,
  input wire logic        wide_mode,
  input wire logic        is_direct,
  input wire logic        via_gate,
  input wire logic [1:0]  target_rpl,
  input wire logic [31:0] rel_disp,
  input wire logic        mem_we,
  input wire logic        mem_re,
  input wire logic [63:0] mem_addr,
  input wire logic [63:0] mem_wdata,
  input wire logic [63:0] mem_rdata,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        protection_fault,
  input wire logic [1:0]  cur_ring,
  input wire logic [15:0] code_sel,
  input wire logic [63:0] wide_instruction_pointer,
  input wire logic [15:0] stack_sel,
  input wire logic [63:0] stack_pointer,
  input wire logic [31:0] flags_register
);
  import pcr_pkg::*;
  logic        go;
  logic [63:0] disp_x;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Accepted request and sign-extended displacement
  assign go     = start && !busy;
  assign disp_x = {{32{rel_disp[31]}}, rel_disp};

  AST_PUSH_ALL_GENERAL_SEQ: assert property (go && op == PCR_OP_PUSHALL |=> mem_we [*8] ##1 done)
    else $error("push-all is not eight writes then done");
  AST_PUSH_ALL_GENERAL_OLD_SP: assert property (go && op == PCR_OP_PUSHALL && wide_mode
    |-> ##5 mem_wdata == $past(stack_pointer, 5))
    else $error("fifth push-all word is not the entry stack pointer");
  AST_POP_ALL_GENERAL_SEQ: assert property (go && op == PCR_OP_POPALL |=> mem_re [*8] ##1 done)
    else $error("pop-all is not eight reads then done");
  AST_POP_ALL_GENERAL_SP: assert property (go && op == PCR_OP_POPALL && wide_mode
    |-> ##9 stack_pointer == $past(stack_pointer, 9) + 64'h40)
    else $error("pop-all stack pointer not advanced by eight words");
  AST_PUSH_FLAGS_WORD_W: assert property (go && op == PCR_OP_PUSH_FLAGS_WORD_W && wide_mode |-> mem_we
    && mem_addr == stack_pointer - 64'h8 && mem_wdata == {48'h0, flags_register[15:0]} ##1 done)
    else $error("word flag push wrong");
  AST_PUSH_FLAGS_WORD_D: assert property (go && op == PCR_OP_PUSH_FLAGS_WORD_D |-> mem_we
    && mem_wdata[31:0] == flags_register)
    else $error("dword flag push wrong data");
  AST_POP_FLAGS_WORD_W: assert property (go && op == PCR_OP_POP_FLAGS_WORD_W
    |=> flags_register[31:16] == $past(flags_register[31:16]))
    else $error("word flag pop touched upper half");
  AST_POP_FLAGS_WORD_D: assert property (go && op == PCR_OP_POP_FLAGS_WORD_D |-> mem_re
    ##1 flags_register == $past(mem_rdata[31:0]))
    else $error("dword flag pop wrong value");
  AST_NEAR_WIDE: assert property (go && op == PCR_OP_NEARBR && wide_mode
    |=> wide_instruction_pointer == $past(wide_instruction_pointer) + $past(disp_x))
    else $error("near branch target not 64-bit sum");
  AST_DIRECT_FAR: assert property (go && op == PCR_OP_FARCALL && wide_mode && is_direct
    |-> !mem_we ##1 protection_fault)
    else $error("direct far call accepted in wide mode");
  AST_SYS_NARROW: assert property (go && (op == PCR_OP_SYSENTRY || op == PCR_OP_SYSEXIT)
    && !wide_mode |=> protection_fault && done)
    else $error("fast entry or exit accepted outside wide mode");
  AST_UNGATED: assert property (go && op == PCR_OP_FARCALL && !via_gate
    && target_rpl < cur_ring |=> protection_fault)
    else $error("ungated inward call not faulted");
  AST_FAULT_FROZEN: assert property (protection_fault |-> done && $stable(cur_ring)
    && $stable(code_sel) && $stable(wide_instruction_pointer) && $stable(stack_sel)
    && $stable(stack_pointer))
    else $error("fault changed architectural state");

  // Main scenarios reached
  cover property (go && op == PCR_OP_FARCALL && via_gate ##[1:40] done && cur_ring == 2'h0);
  cover property (go && op == PCR_OP_FARRET ##[1:8] done && !protection_fault);
  cover property (protection_fault);
endmodule

bind pcr_call_ctrl pcr_call_ctrl_checker i_pcr_call_ctrl_checker (
  .clk(clk), .rst_n(rst_n), .start(start), .op(op), .wide_mode(wide_mode),
  .is_direct(is_direct), .via_gate(via_gate), .target_rpl(target_rpl), .rel_disp(rel_disp),
  .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .busy(busy), .done(done), .protection_fault(protection_fault),
  .cur_ring(cur_ring), .code_sel(code_sel), .wide_instruction_pointer(wide_instruction_pointer),
  .stack_sel(stack_sel), .stack_pointer(stack_pointer), .flags_register(flags_register));

// [sim/tb.sv]
// Self-checking bench for the call/return sequencer.
// Assumes the stack memory answers in the same cycle; bench plays that memory.
`timescale 1ns/10ps
module tb;
  import pcr_pkg::*;
  logic         clk, rst_n, start, wide_mode, opsize_prefix, addr_prefix, is_direct;
  logic         via_gate, ring_wr, mem_we, mem_re, busy, done, protection_fault, flt;
  pcr_op_t      op;
  logic [1:0]   gate_dpl, target_rpl, ring_wr_sel, cur_ring;
  logic [15:0]  gate_cs, ret_bytes, ring_stack_sel, code_sel, stack_sel;
  logic [4:0]   gate_parm_count;
  logic [31:0]  rel_disp, flags_register;
  logic [63:0]  gate_offset, instr_offset, ring_stack_ptr, mem_rdata, mem_addr, mem_wdata;
  logic [63:0]  wide_instruction_pointer, stack_pointer, wide_count_register, accumulator_reg;
  logic [63:0]  data_reg, base_reg, frame_base_pointer, source_index, dest_index, last_wd, last_ra;
  logic [63:0]  mem [65536];
  int           n_errors, compares, cycles;

  pcr_call_ctrl i_pcr_call_ctrl (
    .clk(clk), .rst_n(rst_n), .start(start), .op(op), .wide_mode(wide_mode),
    .opsize_prefix(opsize_prefix), .addr_prefix(addr_prefix), .is_direct(is_direct),
    .via_gate(via_gate), .gate_dpl(gate_dpl), .target_rpl(target_rpl), .gate_cs(gate_cs),
    .gate_offset(gate_offset), .gate_parm_count(gate_parm_count), .instr_offset(instr_offset),
    .rel_disp(rel_disp), .ret_bytes(ret_bytes), .ring_wr(ring_wr), .ring_wr_sel(ring_wr_sel),
    .ring_stack_sel(ring_stack_sel), .ring_stack_ptr(ring_stack_ptr), .mem_rdata(mem_rdata),
    .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .busy(busy), .done(done), .protection_fault(protection_fault), .cur_ring(cur_ring),
    .code_sel(code_sel), .wide_instruction_pointer(wide_instruction_pointer),
    .stack_sel(stack_sel), .stack_pointer(stack_pointer), .flags_register(flags_register),
    .wide_count_register(wide_count_register), .accumulator_reg(accumulator_reg),
    .data_reg(data_reg), .base_reg(base_reg), .frame_base_pointer(frame_base_pointer),
    .source_index(source_index), .dest_index(dest_index));

  // Clock and same-cycle stack memory; only low 16 address bits decoded
  always #5 clk = ~clk;
  assign mem_rdata = mem[mem_addr[15:0]];
  always @(posedge clk) begin
    if (mem_we === 1'b1) begin
      mem[mem_addr[15:0]] <= mem_wdata;
      last_wd <= mem_wdata;
    end
    if (mem_re === 1'b1) last_ra <= mem_addr;
  end

  // Hang guard, far above the 85 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      wrap_up;
    end
  end

  task automatic wrap_up;
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One op: idle edge first so start never toggles twice in a step
  task automatic run_op(input pcr_op_t o);
    int k;
    @(posedge clk); #1;
    op = o;
    start = 1'b1;
    @(posedge clk); #1;
    start = 1'b0;
    op = PCR_OP_NONE;
    k = 0;
    while (done !== 1'b1 && k < 100) begin
      @(posedge clk); #1;
      k++;
    end
    flt = protection_fault;
    if (k == 100) chk(64'h0, 64'h1);
  endtask

  task automatic t_call_ret;
    chk(cur_ring, 2'h3);
    mem[16'h1000] = 64'ha001;
    mem[16'h1008] = 64'ha002;
    ring_wr = 1'b1;
    @(posedge clk); #1;
    ring_wr = 1'b0;
    run_op(PCR_OP_FARCALL);
    chk(flt, 1'b0);
    chk(cur_ring, 2'h0);
    chk(stack_sel, 16'h0010);
    chk(stack_pointer, 64'h7fd0);
    chk(code_sel, 16'h0028);
    chk(wide_instruction_pointer, 64'hffff_8000_0000_1000);
    chk(mem[16'h7ff8], 64'h0);
    chk(mem[16'h7ff0], 64'h1000);
    chk(mem[16'h7fe8], 64'ha002);
    chk(mem[16'h7fe0], 64'ha001);
    chk(mem[16'h7fd8], 64'h0);
    chk(mem[16'h7fd0], 64'h0);
    // Patch the saved frame so the return proves where each field comes from
    mem[16'h7fd0] = 64'h4444;
    mem[16'h7fd8] = 64'h0033;
    mem[16'h7ff0] = 64'h2000;
    mem[16'h7ff8] = 64'h002b;
    via_gate = 1'b0;
    target_rpl = 2'h3;
    run_op(PCR_OP_FARRET);
    chk(flt, 1'b0);
    chk(wide_instruction_pointer, 64'h4444);
    chk(code_sel, 16'h0033);
    chk(last_ra, 64'h7ff8);
    chk(stack_sel, 16'h002b);
    chk(cur_ring, 2'h3);
    chk(stack_pointer, 64'h2010);
  endtask

  task automatic t_gpr;
    logic [63:0] gv [8];
    logic [63:0] got [8];
    for (int r = 0; r < 8; r++) gv[r] = 64'hc0de_0000_0000_0000 + 64'(r);
    gv[1] = 64'h1_0000_0000;
    for (int i = 0; i < 8; i++) mem[16'h2010 + 16'(8 * i)] = gv[7 - i];
    run_op(PCR_OP_POPALL);
    got = '{accumulator_reg, wide_count_register, data_reg, base_reg, 64'h0,
            frame_base_pointer, source_index, dest_index};
    for (int r = 0; r < 8; r++) if (r != 4) chk(got[r], gv[r]);
    chk(stack_pointer, 64'h2050);
    gv[4] = 64'h2050;
    run_op(PCR_OP_PUSHALL);
    for (int k = 0; k < 8; k++) chk(mem[16'h2048 - 16'(8 * k)], gv[k]);
    chk(stack_pointer, 64'h2010);
  endtask

  // Refused cases: ungated inward, direct far, raised return, narrow entry
  task automatic t_faults;
    for (int i = 0; i < 4; i++) begin
      wide_mode = (i != 3);
      via_gate = (i == 1);
      is_direct = (i == 1);
      target_rpl = (i == 2) ? 2'h2 : 2'h0;
      run_op(i == 2 ? PCR_OP_FARRET : (i == 3 ? PCR_OP_SYSENTRY : PCR_OP_FARCALL));
      chk(flt, 1'b1);
      chk(cur_ring, 2'h3);
      chk(code_sel, 16'h0033);
      chk(wide_instruction_pointer, 64'h4444);
      chk(stack_pointer, 64'h2010);
    end
    wide_mode = 1'b1;
    is_direct = 1'b0;
    // Ungated same-ring call and return stay on the live stack
    target_rpl = 2'h3;
    run_op(PCR_OP_FARCALL);
    chk(flt, 1'b0);
    chk(wide_instruction_pointer, 64'h1234);
    chk(stack_pointer, 64'h2000);
    run_op(PCR_OP_FARRET);
    chk(wide_instruction_pointer, 64'h4444);
    chk(stack_pointer, 64'h2020);
  endtask

  task automatic t_sys_branch;
    gate_offset = 64'h0000_7000_0000_0100;
    run_op(PCR_OP_SYSENTRY);
    chk(cur_ring, 2'h0);
    chk(wide_instruction_pointer, 64'h0000_7000_0000_0100);
    gate_offset = 64'h40_0000;
    run_op(PCR_OP_SYSEXIT);
    chk(cur_ring, 2'h3);
    rel_disp = 32'hffff_fff0;
    opsize_prefix = 1'b1;
    run_op(PCR_OP_NEARBR);
    chk(wide_instruction_pointer, 64'h3f_fff0);
    addr_prefix = 1'b1;
    run_op(PCR_OP_JCZ);
    chk(wide_instruction_pointer, 64'h3f_ffe0);
    addr_prefix = 1'b0;
    run_op(PCR_OP_JCZ);
    chk(wide_instruction_pointer, 64'h3f_ffe0);
  endtask

  task automatic t_flags;
    mem[16'h2020] = 64'hffff_0000_1234_5678;
    mem[16'h2028] = 64'h0000_0000_0000_beef;
    run_op(PCR_OP_POP_FLAGS_WORD_D);
    chk(flags_register, 32'h1234_5678);
    run_op(PCR_OP_POP_FLAGS_WORD_W);
    chk(flags_register, 32'h1234_beef);
    run_op(PCR_OP_PUSH_FLAGS_WORD_W);
    chk(last_wd[31:0], 32'h0000_beef);
    run_op(PCR_OP_PUSH_FLAGS_WORD_D);
    chk(last_wd[31:0], 32'h1234_beef);
  endtask

  initial begin
    foreach (mem[i]) mem[i] = {4{16'h5a00 ^ 16'(i)}};
    {clk, rst_n, start, opsize_prefix, addr_prefix, is_direct, ring_wr} = '0;
    {n_errors, compares, cycles} = '0;
    op = PCR_OP_NONE;
    wide_mode = 1'b1;
    via_gate = 1'b1;
    gate_dpl = 2'h0;
    target_rpl = 2'h0;
    gate_cs = 16'h0028;
    gate_offset = 64'hffff_8000_0000_1000;
    instr_offset = 64'h1234;
    gate_parm_count = 5'h2;
    rel_disp = 32'h0;
    ret_bytes = 16'h0010;
    ring_wr_sel = 2'h0;
    ring_stack_sel = 16'h0010;
    ring_stack_ptr = 64'h8000;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    t_call_ret;
    t_gpr;
    t_faults;
    t_sys_branch;
    t_flags;
    wrap_up;
  end
endmodule
